// ---- rtl/bagen_pkg.sv ----
// package of constants and types for the burst address generator
// Functional notes
// - master gives only the first address; this block computes later beat addresses.
// - length field plus one is the beat count, 1 to 16.
// - every burst carries exactly its encoded beat count; no early end.
// - size field gives bytes per beat as two to the field value.
// - narrow incr/wrap beats move across lanes; fixed beats reuse lanes.
// - type field: 00 fixed, 01 incr, 10 wrap, 11 reserved.
// - fixed burst keeps the same address on every beat.
// - incr burst adds beat size to the previous address rounded down to beat size.
// - wrap burst increments then folds back at size times count boundary.
// - beat one uses start address; later beats use aligned address plus size steps.
// - wrap low address is start rounded down to span; reaching top folds to it.
// - first beat lanes: low is start mod bus bytes, high from aligned address.
// - later incr/wrap beats: low is address mod bus bytes, high is low plus size minus one.
// - this block marks the last beat of every burst.
package bagen_pkg;
	localparam int        ADDR_W      = 32;
	localparam int        LEN_W       = 4;
	localparam int        SIZE_W      = 3;
	localparam int        BURST_W     = 2;
	localparam int        CNT_W       = 5;
	localparam int        BOUND_4K_W  = 12;
	localparam logic [LEN_W-1:0] LEN_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
	typedef enum logic [BURST_W-1:0] {
		BAGEN_FIXED = 2'b00,
		BAGEN_INCR  = 2'b01,
		BAGEN_WRAP  = 2'b10,
		BAGEN_RSVD  = 2'b11
	} bagen_burst_t;
	typedef enum logic [0:0] {
		BAGEN_IDLE = 1'b0,
		BAGEN_BUSY = 1'b1
	} bagen_state_t;
endpackage : bagen_pkg

// ---- rtl/bagen_lane.sv ----
// byte-lane strobe decoder for one beat
`timescale 1ns/1ps
module bagen_lane #(
	parameter int BUS_BYTES = 4,
	parameter int LANE_W    = 2
) (
	input  wire logic [LANE_W-1:0]    lane_lo_i,
	input  wire logic [LANE_W-1:0]    lane_hi_i,
	output logic      [BUS_BYTES-1:0] strb_o
);
	genvar g;
	generate
		for (g = 0; g < BUS_BYTES; g++) begin : g_lane
			// data sits in bits 8*lo up to 8*hi+7
			assign strb_o[g] = (LANE_W'(g) >= lane_lo_i) && (LANE_W'(g) <= lane_hi_i);
		end
	endgenerate
endmodule : bagen_lane

// ---- rtl/bagen_top.sv ----
// burst address generator: per-beat address, lanes and last flag
`timescale 1ns/1ps
module bagen_top #(
	parameter int BUS_BYTES = 4,
	parameter int LANE_W    = 2
) (
	input  wire logic                           clk_i,
	input  wire logic                           rst_b_i,
	input  wire logic                           start_i,
	input  wire logic [bagen_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [bagen_pkg::LEN_W-1:0]   len_i,
	input  wire logic [bagen_pkg::SIZE_W-1:0]  size_i,
	input  wire logic [bagen_pkg::BURST_W-1:0] burst_i,
	input  wire logic                           beat_valid_i,
	input  wire logic                           beat_ready_i,
	output logic                                busy_o,
	output logic      [bagen_pkg::ADDR_W-1:0]  beat_addr_o,
	output logic      [BUS_BYTES-1:0]           beat_strb_o,
	output logic                                beat_last_o,
	output logic                                burst_err_o
);
	import bagen_pkg::*;

	bagen_state_t             state;
	bagen_state_t             next_state;
	logic [ADDR_W-1:0]        addr;
	logic [ADDR_W-1:0]        next_addr;
	logic [ADDR_W-1:0]        wrap_lo;
	logic [ADDR_W-1:0]        next_wrap_lo;
	logic [ADDR_W-1:0]        wrap_mask;
	logic [ADDR_W-1:0]        next_wrap_mask;
	logic [SIZE_W-1:0]        size;
	logic [SIZE_W-1:0]        next_size;
	bagen_burst_t             btype;
	bagen_burst_t             next_btype;
	logic [CNT_W-1:0]         left;
	logic [CNT_W-1:0]         next_left;
	logic                     first;
	logic                     next_first;
	logic [BUS_BYTES-1:0]     next_strb;
	logic                     next_err;
	logic [BUS_BYTES-1:0]     strb_w;
	logic [LANE_W-1:0]        lane_lo;
	logic [LANE_W-1:0]        lane_hi;
	logic [ADDR_W-1:0]        step;
	logic [ADDR_W-1:0]        aligned;
	logic [ADDR_W-1:0]        incr_addr;

	// mask of address bits below 2**size
	function automatic logic [ADDR_W-1:0] low_mask(input logic [SIZE_W-1:0] s);
		low_mask = (ADDR_W'(1) << s) - ADDR_W'(1);
	endfunction : low_mask

	// lanes from the held beat state; first beat uses the unaligned start
	always_comb begin
		step      = low_mask(size) + ADDR_W'(1);
		aligned   = addr & ~low_mask(size);
		incr_addr = aligned + step;
		lane_lo   = addr[LANE_W-1:0];
		lane_hi   = LANE_W'(aligned[LANE_W-1:0] + step[LANE_W-1:0] - LANE_W'(1));
		if (size >= SIZE_W'($clog2(BUS_BYTES))) begin
			lane_hi = {LANE_W{1'b1}};
		end
	end

	bagen_lane #(
		.BUS_BYTES (BUS_BYTES),
		.LANE_W    (LANE_W)
	) u_lane (
		.lane_lo_i (lane_lo),
		.lane_hi_i (lane_hi),
		.strb_o    (strb_w)
	);

	always_comb begin
		next_state     = state;
		next_addr      = addr;
		next_wrap_lo   = wrap_lo;
		next_wrap_mask = wrap_mask;
		next_size      = size;
		next_btype     = btype;
		next_left      = left;
		next_first     = first;
		next_err       = burst_err_o;
		next_strb      = strb_w;
		case (state)
			BAGEN_IDLE: begin
				if (start_i) begin
					// master supplies only the first address
					next_addr      = addr_i;
					next_size      = size_i;
					next_btype     = bagen_burst_t'(burst_i);
					next_left      = CNT_W'(len_i) + CNT_ONE;
					next_first     = 1'b1;
					// span mask = size*count - 1; count is a power of two for wrap
					next_wrap_mask = ((ADDR_W'(CNT_W'(len_i) + CNT_ONE)) << size_i) - ADDR_W'(1);
					next_wrap_lo   = addr_i & ~next_wrap_mask;
					next_err       = (burst_i == BAGEN_RSVD) ||
						(burst_i == BAGEN_WRAP && len_i != 4'h1 && len_i != 4'h3 &&
						 len_i != 4'h7 && len_i != 4'hF) ||
						(burst_i == BAGEN_WRAP && (addr_i & low_mask(size_i)) != '0) ||
						(size_i > SIZE_W'($clog2(BUS_BYTES))) ||
						(((addr_i & ADDR_W'(12'hFFF)) + ((ADDR_W'(CNT_W'(len_i) + CNT_ONE)) << size_i)
						  - ADDR_W'(addr_i[0 +: 0+1] & 1'b0)) > ADDR_W'(13'h1000));
					next_state     = BAGEN_BUSY;
				end
			end
			BAGEN_BUSY: begin
				if (beat_valid_i && beat_ready_i) begin
					next_left  = left - CNT_ONE;
					next_first = 1'b0;
					case (btype)
						BAGEN_FIXED: next_addr = addr;
						BAGEN_WRAP: begin
							// fold back when the next beat hits the top of the span
							if ((incr_addr & wrap_mask) == '0) begin
								next_addr = wrap_lo;
							end else begin
								next_addr = incr_addr;
							end
						end
						default: next_addr = incr_addr;
					endcase
					if (left == CNT_ONE) begin
						next_state = BAGEN_IDLE;
					end
				end
			end
			default: next_state = BAGEN_IDLE;
		endcase
	end

	// reset clears beat state and the error flag; other outputs are registered copies
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state       <= BAGEN_IDLE;
			addr        <= '0;
			wrap_lo     <= '0;
			wrap_mask   <= '0;
			size        <= '0;
			btype       <= BAGEN_FIXED;
			left        <= CNT_ZERO;
			first       <= 1'b0;
			burst_err_o <= 1'b0;
		end else begin
			state       <= next_state;
			addr        <= next_addr;
			wrap_lo     <= next_wrap_lo;
			wrap_mask   <= next_wrap_mask;
			size        <= next_size;
			btype       <= next_btype;
			left        <= next_left;
			first       <= next_first;
			burst_err_o <= next_err;
		end
	end

	// output registers track the next beat state so they line up with it
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_o      <= 1'b0;
			beat_addr_o <= '0;
			beat_strb_o <= '0;
			beat_last_o <= 1'b0;
		end else begin
			busy_o      <= (next_state == BAGEN_BUSY);
			beat_addr_o <= next_addr;
			beat_strb_o <= lane_strb(next_addr, next_size);
			beat_last_o <= (next_state == BAGEN_BUSY) && (next_left == CNT_ONE);
		end
	end

	// strobe for a given beat address, same lane equations as the decoder
	function automatic logic [BUS_BYTES-1:0] lane_strb(input logic [ADDR_W-1:0] a,
		input logic [SIZE_W-1:0] s);
		logic [LANE_W:0]   lo;
		logic [LANE_W:0]   hi;
		logic [ADDR_W-1:0] m;
		m  = low_mask(s);
		lo = {1'b0, a[LANE_W-1:0]};
		hi = {1'b0, (a[LANE_W-1:0] & ~m[LANE_W-1:0])} + (LANE_W+1)'(m);
		lane_strb = '0;
		for (int i = 0; i < BUS_BYTES; i++) begin
			lane_strb[i] = ((LANE_W+1)'(i) >= lo) && ((LANE_W+1)'(i) <= hi);
		end
	endfunction : lane_strb
endmodule : bagen_top

// ---- verif/bagen_chk.sv ----
// checker for the burst address generator ports
`timescale 1ns/1ps
module bagen_chk #(parameter int BUS_BYTES = 4, parameter int LANE_W = 2) (
	input wire logic clk_i, rst_b_i, start_i, beat_valid_i, beat_ready_i, busy_o, beat_last_o, burst_err_o,
	input wire logic [31:0] addr_i, beat_addr_o,
	input wire logic [3:0] len_i,
	input wire logic [2:0] size_i,
	input wire logic [1:0] burst_i,
	input wire logic [BUS_BYTES-1:0] beat_strb_o
);
	import bagen_pkg::*;
	logic [1:0] typ;
	logic [31:0] nb, sp, wlo;
	logic [4:0] cnt;
	logic [3:0] ln;
	wire hs = busy_o && beat_valid_i && beat_ready_i;
	// burst controls are captured here because the ports may change mid-burst
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			typ <= 2'h0;
			nb <= 32'h1;
			sp <= 32'h1;
			wlo <= 32'h0;
			cnt <= 5'h00;
			ln <= 4'h0;
		end else if (start_i && !busy_o) begin
			typ <= burst_i;
			nb <= 32'h1 << size_i;
			sp <= (32'h1 << size_i) * (len_i + 1);
			wlo <= addr_i & ~((32'h1 << size_i) * (len_i + 1) - 1);
			cnt <= 5'h00;
			ln <= len_i;
		end else if (hs) begin
			cnt <= cnt + 5'h01;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_start_take: assert property (start_i && !busy_o |=> busy_o && beat_addr_o == $past(addr_i))
		else $error("first beat address wrong");
	a_fixed_same: assert property (typ == BAGEN_FIXED && hs && !beat_last_o |=> $stable(beat_addr_o) && $stable(beat_strb_o))
		else $error("fixed burst moved");
	a_incr_step: assert property (typ == BAGEN_INCR && hs && !beat_last_o |=> beat_addr_o == ($past(beat_addr_o) & ~(nb - 1)) + nb)
		else $error("incr step wrong");
	a_wrap_step: assert property (typ == BAGEN_WRAP && !burst_err_o && hs && !beat_last_o |=>
		beat_addr_o == (($past(beat_addr_o) + nb == wlo + sp) ? wlo : $past(beat_addr_o) + nb)) else $error("wrap step wrong");
	a_stall_hold: assert property (busy_o && !(beat_valid_i && beat_ready_i) |=> $stable(beat_addr_o) && $stable(beat_last_o))
		else $error("beat moved without handshake");
	a_last_done: assert property (hs && beat_last_o |=> !busy_o && !beat_last_o)
		else $error("burst did not end after last");
	a_beat_count: assert property (busy_o |-> beat_last_o == (cnt == {1'b0, ln}))
		else $error("last flag at wrong beat");
	a_lane_later: assert property ((typ == BAGEN_INCR || typ == BAGEN_WRAP) && busy_o && cnt != 0 && nb <= BUS_BYTES |->
		beat_strb_o == BUS_BYTES'(((1 << nb) - 1) << beat_addr_o[LANE_W-1:0])) else $error("later beat lanes wrong");
	a_err_rsvd: assert property (start_i && !busy_o && burst_i == BAGEN_RSVD |=> burst_err_o)
		else $error("reserved type not flagged");
	c_wrap_fold: cover property (typ == BAGEN_WRAP && hs && beat_addr_o + nb == wlo + sp);
	c_stall: cover property (busy_o && !beat_ready_i);
	c_long: cover property (beat_last_o && ln == 4'hF);
endmodule : bagen_chk
bind bagen_top bagen_chk #(.BUS_BYTES(BUS_BYTES), .LANE_W(LANE_W)) u_chk (.clk_i, .rst_b_i, .start_i, .beat_valid_i,
	.beat_ready_i, .busy_o, .beat_last_o, .burst_err_o, .addr_i, .beat_addr_o, .len_i, .size_i, .burst_i, .beat_strb_o);

// ---- verif/bagen_mst.sv ----
// master model: burst commands and a data handshake that can stall
`timescale 1ns/1ps
module bagen_mst (
	input  wire logic        clk_i,
	input  wire logic        stall_i,
	output logic             start_o = 1'b0,
	output logic [31:0]      addr_o = 32'h0,
	output logic [3:0]       len_o = 4'h0,
	output logic [2:0]       size_o = 3'h0,
	output logic [1:0]       burst_o = 2'h0,
	output logic             valid_o = 1'b0,
	output logic             ready_o = 1'b0
);
	logic [1:0] ph = 2'h0;
	// valid drops only after a handshake and every beat is taken
	always @(posedge clk_i) begin
		ph <= ph + 2'h1;
		valid_o <= (valid_o && !ready_o) || !stall_i || ph[1];
		ready_o <= !stall_i || ph[0];
	end
	// only the first address goes out; the bench asks exact bursts, legal ones and two that are flagged as errors
	task automatic issue(input logic [31:0] a, input logic [3:0] l, input logic [2:0] s, input logic [1:0] b);
		@(posedge clk_i);
		start_o <= 1'b1;
		addr_o <= a;
		len_o <= l;
		size_o <= s;
		burst_o <= b;
		@(posedge clk_i);
		start_o <= 1'b0;
		addr_o <= ~a;
	endtask : issue
endmodule : bagen_mst

// ---- verif/bagen_top_tb_top.sv ----
// testbench: table of bursts, every beat of legal bursts compared
`timescale 1ns/1ps
module bagen_top_tb_top;
	import bagen_pkg::*;
	logic clk_i = 1'b0, rst_b_i = 1'b0, stall = 1'b0, start, bv, br, busy, last, err;
	logic [31:0] addr, baddr;
	logic [3:0] len, strb;
	logic [2:0] size;
	logic [1:0] burst;
	int n_errors = 0, check_count = 0;
	always #4 clk_i = ~clk_i;
	bagen_mst u_mst (.clk_i, .stall_i(stall), .start_o(start), .addr_o(addr), .len_o(len), .size_o(size),
		.burst_o(burst), .valid_o(bv), .ready_o(br));
	bagen_top DUT (.clk_i, .rst_b_i, .start_i(start), .addr_i(addr), .len_i(len), .size_i(size), .burst_i(burst),
		.beat_valid_i(bv), .beat_ready_i(br), .busy_o(busy), .beat_addr_o(baddr), .beat_strb_o(strb),
		.beat_last_o(last), .burst_err_o(err));
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [31:0] ea(input logic [31:0] s, input int l, z, b, n);
		logic [31:0] nb, sp;
		nb = 32'h1 << z;
		sp = nb * (l + 1);
		if (n == 0 || b == BAGEN_FIXED) return s;
		ea = (s & ~(nb - 1)) + n * nb;
		if (b == BAGEN_WRAP && ea >= (s & ~(sp - 1)) + sp) ea = ea - sp;
	endfunction : ea
	function automatic logic [3:0] es(input logic [31:0] s, a, input int z, b, n);
		int lo, hi;
		lo = a[1:0];
		hi = (n == 0 || b == BAGEN_FIXED) ? int'(((s >> z) << z) - ((s >> 2) << 2)) + (1 << z) - 1 : lo + (1 << z) - 1;
		es = 4'h0;
		for (int i = lo; i <= hi; i++) es[i] = 1'b1;
	endfunction : es
	// stalled runs also check that the beat holds while waiting
	task automatic run(input logic [31:0] a, input int l, z, b, st, e);
		int n, k;
		logic [31:0] x;
		@(posedge clk_i);
		stall <= st[0];
		u_mst.issue(a, l[3:0], z[2:0], b[1:0]);
		@(negedge clk_i);
		chk("busy", 32'h1, busy);
		chk("err", e, err);
		n = 0;
		for (k = 0; k < 200 && busy === 1'b1; k++) begin
			x = ea(a, l, z, b, n);
			if (e == 0) begin
				chk("addr", x, baddr);
				chk("strb", es(a, x, z, b, n), strb);
				chk("last", n == l, last);
			end
			if (bv && br) n++;
			@(negedge clk_i);
		end
		chk("beats", l + 1, n);
	endtask : run
	initial begin
		repeat (10) @(posedge clk_i);
		chk("rst", 32'h0, {busy, last, err, strb, baddr[24:0]});
		rst_b_i <= 1'b1;
		run(32'h4, 1, 2, BAGEN_INCR, 0, 0);
		run(32'h5, 3, 2, BAGEN_INCR, 1, 0);
		run(32'h2, 3, 0, BAGEN_INCR, 0, 0);
		run(32'h1C, 3, 2, BAGEN_WRAP, 1, 0);
		run(32'hA, 7, 0, BAGEN_WRAP, 0, 0);
		run(32'h6, 1, 1, BAGEN_WRAP, 0, 0);
		run(32'h103, 2, 0, BAGEN_FIXED, 1, 0);
		run(32'h0, 15, 2, BAGEN_INCR, 0, 0);
		run(32'h0, 0, 2, BAGEN_INCR, 0, 0);
		run(32'h0, 1, 2, BAGEN_RSVD, 0, 1);
		run(32'h0, 2, 2, BAGEN_WRAP, 0, 1);
		complete_run();
	end
	initial begin
		#100000;
		n_errors++;
		complete_run();
	end
endmodule : bagen_top_tb_top
